// [verif/adc_serial_output_port_tb.sv]
// Purpose: bench joining converter port and host over the link
// Assumes: conversion shortened to 64 cycles
// Notes:   host reads words itself; bench polls its registers
`timescale 1ns/1ps
`default_nettype none
module adc_serial_output_port_tb;
    import adcsp_pkg::*;
    localparam int SAMPLE_TRIGGER_N = 64;
    logic        clk;
    logic        reset = 1'b1;
    logic [15:0] sample_value = 16'h0000;
    logic [15:0] result_word;
    logic        sample_trigger_n_done;
    logic        result_dropped;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] lfsr_q = 16'h0007;
    logic        drop_seen = 1'b0;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          done_cnt = 0;
    adcsp_if link_if ();
    adcsp_device #(.SAMPLE_TRIGGER_N_CYC(SAMPLE_TRIGGER_N)) adcsp_device_inst (.clk(clk), .reset(reset),
        .link(link_if), .sample_value(sample_value), .result_word(result_word),
        .sample_trigger_n_done(sample_trigger_n_done), .result_dropped(result_dropped));
    adcsp_host adcsp_host_inst (.clk(clk), .reset(reset), .link(link_if),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    adcsp_props adcsp_props_inst (.clk(clk), .reset(reset), .rst_n(link_if.rst_n),
        .chip_sel_n(link_if.chip_sel_n), .serial_mode_select(link_if.serial_mode_select),
        .factory_test_pin(link_if.factory_test_pin), .ready_n(link_if.ready_n),
        .sclk_dev_o(link_if.sclk_dev_o), .sclk_dev_oe(link_if.sclk_dev_oe),
        .sclk_host_oe(link_if.sclk_host_oe), .serial_data_out_o(link_if.serial_data_out_o),
        .serial_data_out_oe(link_if.serial_data_out_oe), .sclk(link_if.sclk));
    // =========
    // clock, timeout
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (result_dropped === 1'b1)
            drop_seen <= 1'b1;
        if (sample_trigger_n_done === 1'b1)
            done_cnt <= done_cnt + 1;
        if (cyc == 30000)
        begin
            fail_count++;
            report_and_stop();
        end
    end
    // =========
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [15:0] exp_word(input logic [15:0] raw, input logic pol);
        return pol ? (raw ^ 16'h8000) : raw;
    endfunction : exp_word
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                            output logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus_xfer
    task automatic poll(input int b, output logic [31:0] d);
        d = 32'h0000_0000;
        for (int n = 0; n < 400 && d[b] !== 1'b1; n++)
            bus_xfer(1'b0, REG_STATUS, 32'h0000_0000, d);
    endtask : poll
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    // =========
    // main sequence
    initial
    begin
        logic [31:0] d;
        logic [15:0] raw;
        logic [15:0] e;
        int          base;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (SAMPLE_TRIGGER_N + 20) @(posedge clk);
        chk("ready_after_reset", 32'h0, {31'h0, link_if.ready_n});
        // flush the word of the conversion that follows reset
        poll(STAT_VALID, d);
        bus_xfer(1'b0, REG_DATA, 32'h0, d);
        chk("reset_word", 32'h0, d);
        bus_xfer(1'b0, REG_CTRL, 32'h0, d);
        chk("ctrl_reset", 32'h0, d);
        bus_xfer(1'b1, REG_DIV, 32'h0000_0005, d);
        bus_xfer(1'b0, REG_DIV, 32'h0, d);
        chk("div_refused", 32'h0000_0008, d);
        bus_xfer(1'b0, 4'h2, 32'h0, d);
        chk("unmapped", 32'h0, d);
        // modes, polarity and held select in all combinations
        for (int i = 0; i < 8; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            raw = (i == 0) ? 16'h0000 : (i == 3) ? 16'hffff : lfsr_q;
            e = exp_word(raw, i[1]);
            sample_value <= raw;
            base = done_cnt;
            bus_xfer(1'b1, REG_DIV, {24'h00_0000, 5'h01, lfsr_q[2:0]}, d);
            bus_xfer(1'b1, REG_CTRL, {26'h000_0000, 1'b0, i[2], i[1], i[0], 2'b01}, d);
            poll(STAT_VALID, d);
            chk("valid", 32'h1, {31'h0, d[STAT_VALID]});
            bus_xfer(1'b0, REG_DATA, 32'h0, d);
            chk("data", {16'h0000, e}, d);
            chk("dev_word", {16'h0000, e}, {16'h0000, result_word});
            chk("sample_trigger_n_count", 32'h1, 32'(done_cnt - base));
            if (i[2]) chk("sdo_hold", {31'h0, e[0]}, {31'h0, link_if.serial_data_out});
        end
        chk("no_drop", 32'h0, {31'h0, drop_seen});
        // back-to-back conversions outrun the reads
        sample_value <= lfsr_next(lfsr_q);
        bus_xfer(1'b1, REG_CTRL, 32'h0000_0013, d);
        poll(STAT_OVER, d);
        chk("overrun", 32'h1, {31'h0, d[STAT_OVER]});
        chk("dropped", 32'h1, {31'h0, drop_seen});
        // device reset through its pin
        bus_xfer(1'b1, REG_CTRL, 32'h0000_0020, d);
        repeat (8) @(posedge clk);
        chk("ready_in_reset", 32'h1, {31'h0, link_if.ready_n});
        bus_xfer(1'b1, REG_CTRL, 32'h0, d);
        for (int n = 0; n < 200 && link_if.ready_n !== 1'b0; n++)
            @(posedge clk);
        chk("ready_after_pin", 32'h0, {31'h0, link_if.ready_n});
        report_and_stop();
    end
endmodule : adc_serial_output_port_tb
`default_nettype wire

// [verif/adcsp_props.sv]
// Purpose: link checks between converter port and host
// Assumes: one clock domain; device pin reset counts as reset
// Notes:   pins cross two-flop synchronisers, hence the settle runs
`timescale 1ns/1ps
`default_nettype none
module adcsp_props (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // link pins
    input wire logic rst_n,
    input wire logic chip_sel_n,
    input wire logic serial_mode_select,
    input wire logic factory_test_pin,
    input wire logic ready_n,
    input wire logic sclk_dev_o,
    input wire logic sclk_dev_oe,
    input wire logic sclk_host_oe,
    input wire logic serial_data_out_o,
    input wire logic serial_data_out_oe,
    input wire logic sclk
);
    // =========
    // edge count
    logic       sclk_q;
    logic [4:0] edge_cnt_q;
    logic [4:0] edge_now;
    logic [4:0] edge_cnt_d;
    // includes an edge seen this cycle, so a same-cycle ready rise still counts 17
    assign edge_now   = edge_cnt_q + {4'h0, sclk & ~sclk_q};
    assign edge_cnt_d = ready_n ? 5'h00 : edge_now;
    always_ff @(posedge clk)
    begin
        sclk_q     <= reset ? 1'b0 : sclk;
        edge_cnt_q <= reset ? 5'h00 : edge_cnt_d;
    end
    // =========
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || !rst_n);
    AST_SDO_FLOAT: assert property (chip_sel_n [*5] |-> !serial_data_out_oe)
        else $error("data pin driven while deselected");
    AST_SCLK_FLOAT: assert property (chip_sel_n [*5] |-> !sclk_dev_oe)
        else $error("clock pin driven while deselected");
    AST_EXT_CLK: assert property (!serial_mode_select [*5] |-> !sclk_dev_oe)
        else $error("device drives clock in external mode");
    AST_SELF_CLK: assert property (serial_mode_select [*5] |-> !sclk_host_oe)
        else $error("host drives clock in self mode");
    AST_CLK_IN_FRAME: assert property ($rose(sclk_dev_o) && sclk_dev_oe |-> !$past(ready_n))
        else $error("self clock runs without a word");
    AST_SHIFT_RISE: assert property (serial_data_out_oe && $changed(serial_data_out_o)
        && !(ready_n | $past(ready_n) | $past(ready_n, 2)) |-> sclk)
        else $error("data bit changed while clock low");
    AST_READ_LEN: assert property ($rose(ready_n) |-> edge_now == 5'h11 || edge_now == 5'h00)
        else $error("ready rose after a partial word");
    AST_READY_LEAD: assert property ($rose(ready_n) && edge_now == 5'h00
        |-> ##[2:3] $fell(ready_n))
        else $error("unread word not replaced two cycles on");
    AST_TEST_LOW: assert property (factory_test_pin == 1'b0)
        else $error("factory test pin not low");
    COV_FULL_READ: cover property ($rose(ready_n) && edge_now == 5'h11);
    COV_SELF_CLK: cover property ($rose(sclk_dev_o) && sclk_dev_oe);
    COV_UNREAD: cover property ($rose(ready_n) && edge_now == 5'h00);
endmodule : adcsp_props
`default_nettype wire

// [verilog/adcsp_device.sv]
// Purpose: converter side: conversion sequencing and serial output port
// Assumes: clk is the master clock; all link inputs asynchronous
// Notes:   result value comes from the user port as raw offset binary
`timescale 1ns/1ps
`default_nettype none
module adcsp_device
    import adcsp_pkg::*;
#(
    parameter int SAMPLE_TRIGGER_N_CYC  = adcsp_pkg::SAMPLE_TRIGGER_N_CYCLES,
    parameter int SCLK_HALF = adcsp_pkg::SCLK_HALF_DEF
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // link pins
    adcsp_if.device          link,
    // user side
    input  wire logic [15:0] sample_value,
    output logic      [15:0] result_word,
    output logic             sample_trigger_n_done,
    output logic             result_dropped
);
    import adcsp_pkg::*;

    localparam int CW = $clog2(SAMPLE_TRIGGER_N_CYC + 1);
    localparam int DW = $clog2(SCLK_HALF + 1);
    localparam logic [CW-1:0] SAMPLE_TRIGGER_N_LAST = CW'(SAMPLE_TRIGGER_N_CYC - 1);
    localparam logic [CW-1:0] RDY_LEAD  = CW'(RDY_LEAD_CYCLES);
    localparam logic [DW-1:0] HALF_LAST = DW'(SCLK_HALF - 1);
    localparam logic [4:0]    EDGE_LAST = 5'(SHIFT_EDGES - 1);

    if (SAMPLE_TRIGGER_N_CYC <= RDY_LEAD_CYCLES + 1 || SCLK_HALF < SCLK_HALF_MIN)
    begin : g_bad_param
        $error("adcsp_device: conversion or clock divider too short");
    end

    // ========================================================
    // input synchronisers
    wire [5:0] pins_raw = {link.rst_n, link.sample_trigger_n, link.chip_sel_n,
                           link.serial_mode_select, link.polarity_select, link.sclk};
    logic [5:0] pins_meta_q;
    logic [5:0] pins_q;
    always_ff @(posedge clk)
    begin
        pins_meta_q <= pins_raw;
        pins_q      <= pins_meta_q;
    end
    wire rst_pin_n = pins_q[5];
    wire trig_n    = pins_q[4];
    wire cs_n      = pins_q[3];
    wire self_mode = pins_q[2];
    wire pol_twos  = pins_q[1];
    wire sclk_s    = pins_q[0];

    // ========================================================
    // state
    typedef enum logic [1:0] {ADCSP_HELD, ADCSP_IDLE, ADCSP_SAMPLE_TRIGGER_N} adcsp_state_t;
    adcsp_state_t      state_q;
    logic [CW-1:0]     sample_trigger_n_cnt_q;
    logic [15:0]       word_q;
    logic              pending_q;
    logic              reading_q;
    logic [4:0]        edge_q;
    logic              ready_n_q;
    logic              sdo_q;
    logic              sdo_oe_q;
    logic              sclk_oe_q;
    logic              sclk_gen_q;
    logic [DW-1:0]     div_q;
    logic              sclk_prev_q;
    logic [15:0]       result_q;
    logic              done_q;
    logic              drop_q;

    // ========================================================
    // decode
    wire sample_trigger_n_end   = (state_q == ADCSP_SAMPLE_TRIGGER_N) && (sample_trigger_n_cnt_q == '0);
    wire early_rdy  = (state_q == ADCSP_SAMPLE_TRIGGER_N) && (sample_trigger_n_cnt_q == RDY_LEAD);
    wire div_tick   = (reading_q || sclk_gen_q) && self_mode && (div_q == HALF_LAST);
    wire self_rise  = div_tick && !sclk_gen_q;
    wire ext_rise   = !self_mode && !cs_n && sclk_s && !sclk_prev_q;
    wire ext_start  = pending_q && !reading_q && ext_rise;
    wire take_edge  = (reading_q && (self_mode ? self_rise : ext_rise)) || ext_start;
    wire last_edge  = take_edge && (edge_q == EDGE_LAST);
    wire load_word  = sample_trigger_n_end && !reading_q && !ext_start;
    wire self_start = load_word && self_mode && !cs_n;
    wire [15:0] coded = pol_twos ? (sample_value ^ TWOS_FLIP) : sample_value;
    wire [4:0]  bit_ix = 5'(WORD_BITS - 1) - edge_q;

    // ========================================================
    // conversion sequencing
    always_ff @(posedge clk)
    begin
        if (reset || !rst_pin_n)
        begin
            state_q    <= ADCSP_HELD;
            sample_trigger_n_cnt_q <= SAMPLE_TRIGGER_N_LAST;
        end
        else
        begin
            unique case (state_q)
                ADCSP_HELD:
                begin
                    state_q    <= ADCSP_SAMPLE_TRIGGER_N;
                    sample_trigger_n_cnt_q <= SAMPLE_TRIGGER_N_LAST;
                end
                ADCSP_IDLE:
                begin
                    if (!trig_n)
                    begin
                        state_q    <= ADCSP_SAMPLE_TRIGGER_N;
                        sample_trigger_n_cnt_q <= SAMPLE_TRIGGER_N_LAST;
                    end
                end
                ADCSP_SAMPLE_TRIGGER_N:
                begin
                    if (sample_trigger_n_end)
                    begin
                        state_q    <= trig_n ? ADCSP_IDLE : ADCSP_SAMPLE_TRIGGER_N;
                        sample_trigger_n_cnt_q <= SAMPLE_TRIGGER_N_LAST;
                    end
                    else
                    begin
                        sample_trigger_n_cnt_q <= sample_trigger_n_cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // ========================================================
    // output word register and ready flag
    always_ff @(posedge clk)
    begin
        if (reset || !rst_pin_n)
        begin
            word_q    <= '0;
            pending_q <= 1'b0;
            ready_n_q <= 1'b1;
        end
        else if (load_word)
        begin
            word_q    <= coded;
            pending_q <= !self_start;
            ready_n_q <= 1'b0;
        end
        else
        begin
            if (ext_start)
                pending_q <= 1'b0;
            if (last_edge)
                ready_n_q <= 1'b1;
            else if (early_rdy && !reading_q && !ext_start)
                ready_n_q <= 1'b1;
        end
    end

    // ========================================================
    // shifter: one bit per rising shift-clock edge
    // the extra edge lets the receiver capture the last bit
    always_ff @(posedge clk)
    begin
        if (reset || !rst_pin_n)
        begin
            reading_q <= 1'b0;
            edge_q    <= '0;
            sdo_q     <= 1'b0;
        end
        else if (self_start)
        begin
            reading_q <= 1'b1;
            edge_q    <= '0;
        end
        else if (take_edge)
        begin
            reading_q <= !last_edge;
            edge_q    <= last_edge ? 5'd0 : edge_q + 5'd1;
            if (edge_q < 5'(WORD_BITS))
                sdo_q <= word_q[bit_ix[3:0]];
        end
    end

    // ========================================================
    // self-clock divider, idles low
    always_ff @(posedge clk)
    begin
        if (reset || !rst_pin_n)
        begin
            div_q      <= '0;
            sclk_gen_q <= 1'b0;
        end
        else if (div_tick)
        begin
            div_q      <= '0;
            sclk_gen_q <= !sclk_gen_q;
        end
        else if ((reading_q || sclk_gen_q) && self_mode)
        begin
            div_q <= div_q + 1'b1;
        end
        else
        begin
            div_q <= '0;
        end
    end

    // ========================================================
    // pin enables and user outputs
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sdo_oe_q    <= 1'b0;
            sclk_oe_q   <= 1'b0;
            sclk_prev_q <= 1'b0;
            result_q    <= '0;
            done_q      <= 1'b0;
            drop_q      <= 1'b0;
        end
        else
        begin
            sdo_oe_q    <= !cs_n;
            sclk_oe_q   <= self_mode && !cs_n;
            sclk_prev_q <= sclk_s;
            done_q      <= sample_trigger_n_end && rst_pin_n;
            drop_q      <= sample_trigger_n_end && rst_pin_n && !load_word;
            if (load_word && rst_pin_n)
                result_q <= coded;
        end
    end

    assign link.ready_n            = ready_n_q;
    assign link.serial_data_out_o  = sdo_q;
    assign link.serial_data_out_oe = sdo_oe_q;
    assign link.sclk_dev_o         = sclk_gen_q;
    assign link.sclk_dev_oe        = sclk_oe_q;
    assign result_word             = result_q;
    assign sample_trigger_n_done               = done_q;
    assign result_dropped          = drop_q;
endmodule : adcsp_device
`default_nettype wire

// [verilog/adcsp_host.sv]
// Purpose: host controller: starts conversions and reads words off the link
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   captures on synchronised link clock, so half period >= 8 cycles
`timescale 1ns/1ps
`default_nettype none
module adcsp_host
    import adcsp_pkg::*;
#(
    parameter int DIV_W = 8
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // link pins
    adcsp_if.host            link,
    // register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import adcsp_pkg::*;

    localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(SCLK_HALF_DEF);
    localparam logic [4:0]       EDGE_LAST = 5'(SHIFT_EDGES - 1);
    localparam logic [2:0]       TRIG_LAST = 3'(TRIG_PULSE_CYCLES - 1);

    if (DIV_W < 4 || DIV_W > 16 || TRIG_PULSE_CYCLES < 3 || TRIG_PULSE_CYCLES > 8)
    begin : g_bad_param
        $error("adcsp_host: DIV_W out of range");
    end

    typedef enum logic {ADCSP_H_IDLE, ADCSP_H_SHIFT} adcsp_hstate_t;

    // ========================================================
    // synchronisers
    wire  [2:0] raw = {link.ready_n, link.sclk, link.serial_data_out};
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sdo_prev_q;
    always_ff @(posedge clk)
    begin
        meta_q     <= raw;
        sync_q     <= meta_q;
        sdo_prev_q <= sync_q[0];
    end
    wire rdy_n_s = sync_q[2];
    wire sclk_s  = sync_q[1];
    // one sample older: in self-clock mode data and clock edges land together
    wire sdo_s   = sdo_prev_q;

    adcsp_hstate_t    st_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_cnt_q;
    logic [15:0]      shift_q;
    logic [15:0]      data_q;
    logic             valid_q;
    logic             over_q;
    logic             trig_low_q;
    logic [2:0]       trig_cnt_q;
    logic             cs_n_q;
    logic             sclk_q;
    logic [4:0]       gen_q;
    logic [4:0]       cap_q;
    logic             rdy_prev_q;
    logic             sclk_prev_q;
    logic             wait_q;
    logic [31:0]      rdata_q;

    // ========================================================
    // bus decode
    wire req      = avs_read || avs_write;
    wire take     = req && !wait_q;
    wire wr_ctrl  = take && avs_write && (avs_address == REG_CTRL);
    wire wr_div   = take && avs_write && (avs_address == REG_DIV);
    wire rd_data  = take && avs_read && (avs_address == REG_DATA);
    wire rdy_fall = rdy_prev_q && !rdy_n_s;
    wire rise     = sclk_s && !sclk_prev_q;
    wire self_m   = ctrl_q[CTRL_SELF];
    wire word_end = (st_q == ADCSP_H_SHIFT) && rise && (cap_q == EDGE_LAST);
    // clock keeps running after the frame only to bring it back low
    wire gen_run  = (st_q == ADCSP_H_SHIFT || sclk_q) && !self_m;
    wire gen_tick = gen_run && (div_cnt_q >= div_q - 1'b1)
                    && (sclk_q || gen_q != 5'(SHIFT_EDGES));
    wire [31:0] status = {28'h000_0000, !rdy_n_s, (st_q == ADCSP_H_SHIFT), over_q, valid_q};
    wire [31:0] rmux = (avs_address == REG_CTRL)   ? {26'h000_0000, ctrl_q} :
                       (avs_address == REG_STATUS) ? status :
                       (avs_address == REG_DATA)   ? {16'h0000, data_q} :
                       (avs_address == REG_DIV)    ? 32'(div_q) : 32'h0000_0000;

    // one wait cycle, then the answer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end
        else
        begin
            wait_q  <= !(req && wait_q);
            rdata_q <= rmux;
        end
    end

    // ========================================================
    // control registers and trigger
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl_q     <= CTRL_RESET;
            div_q      <= DIV_RESET;
            trig_low_q <= 1'b0;
            trig_cnt_q <= '0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= avs_writedata[CTRL_W-1:0] & ~(CTRL_W'(1) << CTRL_START);
            if (wr_div && avs_writedata[DIV_W-1:0] >= DIV_W'(SCLK_HALF_MIN))
                div_q <= avs_writedata[DIV_W-1:0];
            // short pulse: a trigger still low at ready fall restarts
            if (wr_ctrl && avs_writedata[CTRL_START])
            begin
                trig_low_q <= 1'b1;
                trig_cnt_q <= '0;
            end
            else if (trig_low_q && trig_cnt_q != TRIG_LAST)
                trig_cnt_q <= trig_cnt_q + 3'd1;
            else if (!ctrl_q[CTRL_CONT])
                trig_low_q <= 1'b0;
        end
    end

    // ========================================================
    // read sequencer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_q        <= ADCSP_H_IDLE;
            cs_n_q      <= 1'b1;
            sclk_q      <= 1'b0;
            div_cnt_q   <= '0;
            gen_q       <= '0;
            cap_q       <= '0;
            shift_q     <= '0;
            data_q      <= '0;
            valid_q     <= 1'b0;
            over_q      <= 1'b0;
            rdy_prev_q  <= 1'b1;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            rdy_prev_q  <= rdy_n_s;
            sclk_prev_q <= sclk_s;
            div_cnt_q   <= gen_tick ? '0 :
                           gen_run ? div_cnt_q + 1'b1 : '0;
            if (gen_tick)
            begin
                sclk_q <= !sclk_q;
                if (!sclk_q)
                    gen_q <= gen_q + 5'd1;
            end
            if (st_q == ADCSP_H_IDLE && rdy_fall)
            begin
                st_q  <= ADCSP_H_SHIFT;
                gen_q <= '0;
                cap_q <= '0;
            end
            else if (rise && st_q == ADCSP_H_SHIFT)
            begin
                cap_q <= cap_q + 5'd1;
                if (cap_q != 5'd0)
                    shift_q <= {shift_q[14:0], sdo_s};
            end
            if (word_end)
            begin
                st_q    <= ADCSP_H_IDLE;
                data_q  <= {shift_q[14:0], sdo_s};
                over_q  <= over_q || valid_q;
            end
            valid_q <= word_end || (valid_q && !rd_data);
            cs_n_q  <= !(self_m || ctrl_q[CTRL_HOLD]
                       || (st_q == ADCSP_H_SHIFT && !word_end));
        end
    end

    assign link.rst_n              = !ctrl_q[CTRL_RST];
    assign link.sample_trigger_n   = !trig_low_q;
    assign link.chip_sel_n         = cs_n_q;
    assign link.serial_mode_select = ctrl_q[CTRL_SELF];
    assign link.polarity_select    = ctrl_q[CTRL_POL];
    assign link.factory_test_pin   = 1'b0;
    assign link.sclk_host_o        = sclk_q;
    assign link.sclk_host_oe       = !ctrl_q[CTRL_SELF];
    assign avs_readdata            = rdata_q;
    assign avs_waitrequest         = wait_q;
endmodule : adcsp_host
`default_nettype wire

// [verilog/adcsp_if.sv]
// Purpose: pin bundle between converter port and host
// Assumes: shared pins resolved here from enables
// Notes:   an undriven pin reads low
`timescale 1ns/1ps
`default_nettype none
interface adcsp_if;
    logic rst_n;
    logic sample_trigger_n;
    logic chip_sel_n;
    logic serial_mode_select;
    logic polarity_select;
    logic factory_test_pin;
    logic ready_n;
    logic sclk_dev_o;
    logic sclk_dev_oe;
    logic sclk_host_o;
    logic sclk_host_oe;
    logic serial_data_out_o;
    logic serial_data_out_oe;
    wire  sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe & sclk_host_o);
    wire  serial_data_out = serial_data_out_oe & serial_data_out_o;

    modport device (
        input  rst_n, sample_trigger_n, chip_sel_n, serial_mode_select,
        input  polarity_select, factory_test_pin, sclk,
        output ready_n, sclk_dev_o, sclk_dev_oe, serial_data_out_o, serial_data_out_oe
    );
    modport host (
        output rst_n, sample_trigger_n, chip_sel_n, serial_mode_select,
        output polarity_select, factory_test_pin, sclk_host_o, sclk_host_oe,
        input  ready_n, sclk, serial_data_out
    );
endinterface : adcsp_if
`default_nettype wire

// [verilog/adcsp_pkg.sv]
// Purpose: shared constants for the converter serial output port and its host
// Assumes: both ends run clk at 250 MHz; link signals cross by two flops
// Notes:   register map belongs to the host controller
`default_nettype none
package adcsp_pkg;
    // ========================================================
    // link timing
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SAMPLE_TRIGGER_N_TIME_NS    = 10000;
    localparam int SAMPLE_TRIGGER_N_CYCLES     = SAMPLE_TRIGGER_N_TIME_NS / CLK_PERIOD_NS;
    localparam int RDY_LEAD_CYCLES = 2;
    localparam int TRIG_PULSE_CYCLES = 4;
    localparam int SCLK_HALF_DEF   = 8;
    localparam int SCLK_HALF_MIN   = 8;
    localparam int WORD_BITS       = 16;
    localparam int SHIFT_EDGES     = WORD_BITS + 1;
    localparam logic [15:0] TWOS_FLIP = 16'h8000;
    // ========================================================
    // host register map (byte addresses)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_DATA   = 4'h8;
    localparam logic [3:0] REG_DIV    = 4'hc;
    localparam int CTRL_START = 0;
    localparam int CTRL_CONT  = 1;
    localparam int CTRL_SELF  = 2;
    localparam int CTRL_POL   = 3;
    localparam int CTRL_HOLD  = 4;
    localparam int CTRL_RST   = 5;
    localparam int CTRL_W     = 6;
    localparam int STAT_VALID = 0;
    localparam int STAT_OVER  = 1;
    localparam int STAT_BUSY  = 2;
    localparam int STAT_RDY   = 3;
    localparam logic [5:0] CTRL_RESET = 6'h00;
endpackage : adcsp_pkg
`default_nettype wire
